// *** hdl/snrc_pkg.sv ***
package snrc_pkg;

  // ----------------------------------------------------------------
  // register numbers on the configuration port
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_SWITCH_CFG = 8'h04;
  localparam logic [7:0] REG_NODE_ID = 8'h05;
  localparam logic [7:0] REG_SWITCH_CLOCK_RATIO = 8'h07;
  localparam logic [7:0] REG_REFERENCE_CLOCK_RATIO = 8'h08;
  localparam logic [7:0] REG_JTAG_IDENTITY = 8'h09;
  localparam logic [7:0] REG_USER_CODE = 8'h0a;
  localparam logic [7:0] REG_ROUTE_DIR_LOW = 8'h0c;
  localparam logic [7:0] REG_ROUTE_DIR_HIGH = 8'h0d;
  localparam logic [7:0] REG_SPARE_A = 8'h10;
  localparam logic [7:0] REG_SPARE_B = 8'h11;
  localparam logic [7:0] REG_DEBUG_EVENT_ORIGIN = 8'h1f;
  localparam logic [7:0] REG_EXT_LINK_STATE = 8'h20;
  localparam logic [7:0] REG_PROC_LINK_STATE = 8'h40;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_LOCK_BIT = 31;
  localparam int CFG_PLL_LOCK_BIT = 8;
  localparam int CFG_HDR_BIT = 0;
  localparam int DBG_RSV_BIT = 4;
  localparam int LS_TARGET_LSB = 24;
  localparam int LS_DEST_LSB = 16;
  localparam int LS_DIR_LSB = 8;
  localparam int LS_NET_LSB = 4;
  localparam int LS_JUNK_BIT = 2;
  localparam int LS_DEST_BUSY_BIT = 1;
  localparam int LS_SRC_BUSY_BIT = 0;
  localparam int UC_OTP_LSB = 18;
  localparam int JID_PART_LSB = 12;
  localparam int JID_MAKER_LSB = 1;
  localparam int JID_VERSION_LSB = 28;
  localparam logic [15:0] SWITCH_CLOCK_RATIO_RESET = 16'h0000;
  localparam logic [15:0] REFERENCE_CLOCK_RATIO_RESET = 16'h0003;
  localparam int NUM_EXT_LINK = 9;
  localparam int NUM_PROC_LINK = 8;

  // source_target_type encodings
  localparam logic [1:0] TGT_SWITCH_LINK = 2'h0;
  localparam logic [1:0] TGT_PROCESSOR_LINK = 2'h1;
  localparam logic [1:0] TGT_SWITCH_CONTROL = 2'h2;
  localparam logic [1:0] TGT_UNDEFINED = 2'h3;

endpackage

// *** hdl/snrc_route_if.sv ***
`timescale 1ns/1ps
// carries one routing lookup between the register block and the picker
interface snrc_route_if;
  logic [15:0] dest;
  logic [15:0] local_id;
  logic [31:0] dir_lo;
  logic [31:0] dir_hi;
  logic is_local;
  logic [3:0] dir;
  modport client (output dest, output local_id, output dir_lo, output dir_hi, input is_local, input dir);
  modport picker (input dest, input local_id, input dir_lo, input dir_hi, output is_local, output dir);
endinterface

// *** hdl/snrc_route_pick.sv ***
`timescale 1ns/1ps
module snrc_route_pick
(
  // lookup request and answer
  snrc_route_if.picker rt
);
  logic [15:0] diff;
  logic [3:0] dim;
  logic [63:0] table_all;

  // ----------------------------------------------------------------
  // most significant mismatching bit picks the dimension
  // ----------------------------------------------------------------
  assign diff = rt.dest ^ rt.local_id;
  assign table_all = {rt.dir_hi, rt.dir_lo};

  // later iterations override earlier ones, so the highest bit wins
  always_comb
  begin
    dim = 4'h0;
    for (int b = 0; b < 16; b++)
    begin
      if (diff[b])
      begin
        dim = 4'(b);
      end
    end
  end

  // nibble n of the joined tables is dimension n
  assign rt.dir = table_all[{dim, 2'b00} +: 4];
  assign rt.is_local = (diff == 16'h0000);

endmodule

// *** hdl/snrc_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// - switch clock ratio, 16 bits, reset zero
// - reference clock ratio, 16 bits, reset three
// - highest mismatching id bit selects direction
// - id bits 7..0 use low table
// - id bits 15..8 use high table
// - read-only jtag identity word, four fields
// - user code: otp high, metal id low
// - debug origin bits mark causing processor
// - link status shows source target type
// - link status shows destination link number
// - external links hold writable 4-bit direction
// - every link holds writable network number
// - junk flag while current packet discarded
// - busy flags for destination and source sides
// - external link registers from 0x20 upward
// - processor link registers 0x40 to 0x47
// - spare registers keep two writable bits
// - writable local node id, reset zero
// - lock bit blocks control register writes
module snrc_top
  import snrc_pkg::*;
#(
  parameter int NX = NUM_EXT_LINK,
  parameter int NP = NUM_PROC_LINK,
  parameter logic [3:0] JTAG_VERSION = 4'h1, // arbitrary value
  parameter logic [15:0] JTAG_PART = 16'h0001, // arbitrary value
  parameter logic [10:0] JTAG_MAKER = 11'h001, // arbitrary value
  parameter logic [17:0] METAL_ID = 18'h00001 // arbitrary value
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // configuration port
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // routing lookup
  input wire logic rt_valid,
  input wire logic [15:0] rt_dest,
  output logic rt_done,
  output logic rt_local,
  output logic [3:0] rt_dir,
  // identity and debug sources
  input wire logic [13:0] otp_user_code,
  input wire logic dbg_event,
  input wire logic dbg_core,
  // external link status
  input wire logic [2*NX-1:0] xl_target,
  input wire logic [8*NX-1:0] xl_dest,
  input wire logic [NX-1:0] xl_junk,
  input wire logic [NX-1:0] xl_dest_busy,
  input wire logic [NX-1:0] xl_src_busy,
  // processor link status
  input wire logic [2*NP-1:0] pl_target,
  input wire logic [8*NP-1:0] pl_dest,
  input wire logic [NP-1:0] pl_junk,
  input wire logic [NP-1:0] pl_dest_busy,
  input wire logic [NP-1:0] pl_src_busy,
  // settings towards the switch
  output logic [15:0] switch_clock_ratio,
  output logic [15:0] reference_clock_ratio,
  output logic [15:0] node_id,
  output logic pll_write_lock,
  output logic one_byte_header,
  output logic [3:0] spare_bits,
  output logic [4*NX-1:0] xl_dir,
  output logic [2*NX-1:0] xl_net,
  output logic [2*NP-1:0] pl_net
);

  typedef struct packed {
    logic lock;
    logic pll_lock;
    logic hdr1;
    logic [15:0] node_id;
    logic [15:0] sw_ratio;
    logic [15:0] ref_ratio;
    logic [31:0] dir_lo;
    logic [31:0] dir_hi;
    logic [1:0] spare_a;
    logic [1:0] spare_b;
    logic [1:0] dbg_src;
    logic dbg_rsv;
    logic [NX-1:0][3:0] xl_dir;
    logic [NX-1:0][1:0] xl_net;
    logic [NP-1:0][1:0] pl_net;
    logic ack;
    logic [31:0] rdata;
    logic rt_done;
    logic rt_local;
    logic [3:0] rt_dir;
  } snrc_state_t;

  snrc_state_t st_r;
  snrc_state_t st_nxt;
  logic [31:0] xl_word [NX];
  logic [31:0] pl_word [NP];
  logic wr_ok;
  logic rd_ok;
  snrc_route_if rt_bus ();

  // ----------------------------------------------------------------
  // route lookup
  // ----------------------------------------------------------------
  assign rt_bus.dest = rt_dest;
  assign rt_bus.local_id = st_r.node_id;
  assign rt_bus.dir_lo = st_r.dir_lo;
  assign rt_bus.dir_hi = st_r.dir_hi;

  snrc_route_pick u_pick
  (
    .rt (rt_bus.picker)
  );

  // ----------------------------------------------------------------
  // link status words, reserved bits tied to zero
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NX; i++)
  begin : g_xl
    always_comb
    begin
      xl_word[i] = 32'h0000_0000;
      xl_word[i][LS_TARGET_LSB +: 2] = xl_target[2*i +: 2];
      xl_word[i][LS_DEST_LSB +: 8] = xl_dest[8*i +: 8];
      xl_word[i][LS_DIR_LSB +: 4] = st_r.xl_dir[i];
      xl_word[i][LS_NET_LSB +: 2] = st_r.xl_net[i];
      xl_word[i][LS_JUNK_BIT] = xl_junk[i];
      xl_word[i][LS_DEST_BUSY_BIT] = xl_dest_busy[i];
      xl_word[i][LS_SRC_BUSY_BIT] = xl_src_busy[i];
    end
  end

  for (genvar i = 0; i < NP; i++)
  begin : g_pl
    // same layout as external links but without a direction
    always_comb
    begin
      pl_word[i] = 32'h0000_0000;
      pl_word[i][LS_TARGET_LSB +: 2] = pl_target[2*i +: 2];
      pl_word[i][LS_DEST_LSB +: 8] = pl_dest[8*i +: 8];
      pl_word[i][LS_NET_LSB +: 2] = st_r.pl_net[i];
      pl_word[i][LS_JUNK_BIT] = pl_junk[i];
      pl_word[i][LS_DEST_BUSY_BIT] = pl_dest_busy[i];
      pl_word[i][LS_SRC_BUSY_BIT] = pl_src_busy[i];
    end
  end

  // lock is a one-way door: once set, only reset reopens the block
  assign wr_ok = cfg_valid & cfg_write & ~st_r.lock;
  assign rd_ok = cfg_valid & ~cfg_write;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack = cfg_valid;
    st_nxt.rdata = 32'h0000_0000;
    st_nxt.rt_done = rt_valid;
    if (rt_valid)
    begin
      st_nxt.rt_local = rt_bus.is_local;
      st_nxt.rt_dir = rt_bus.is_local ? 4'h0 : rt_bus.dir;
    end

    // register writes
    if (wr_ok)
    begin
      case (cfg_addr)
        REG_SWITCH_CFG:
        begin
          st_nxt.lock = cfg_wdata[CFG_LOCK_BIT];
          st_nxt.pll_lock = cfg_wdata[CFG_PLL_LOCK_BIT];
          st_nxt.hdr1 = cfg_wdata[CFG_HDR_BIT];
        end
        REG_NODE_ID: st_nxt.node_id = cfg_wdata[15:0];
        REG_SWITCH_CLOCK_RATIO: st_nxt.sw_ratio = cfg_wdata[15:0];
        REG_REFERENCE_CLOCK_RATIO: st_nxt.ref_ratio = cfg_wdata[15:0];
        REG_ROUTE_DIR_LOW: st_nxt.dir_lo = cfg_wdata;
        REG_ROUTE_DIR_HIGH: st_nxt.dir_hi = cfg_wdata;
        REG_SPARE_A: st_nxt.spare_a = cfg_wdata[1:0];
        REG_SPARE_B: st_nxt.spare_b = cfg_wdata[1:0];
        REG_DEBUG_EVENT_ORIGIN:
        begin
          st_nxt.dbg_src = cfg_wdata[1:0];
          st_nxt.dbg_rsv = cfg_wdata[DBG_RSV_BIT];
        end
        default:
        begin
        end
      endcase
      for (int i = 0; i < NX; i++)
      begin
        if (cfg_addr == REG_EXT_LINK_STATE + 8'(i))
        begin
          st_nxt.xl_dir[i] = cfg_wdata[LS_DIR_LSB +: 4];
          st_nxt.xl_net[i] = cfg_wdata[LS_NET_LSB +: 2];
        end
      end
      for (int i = 0; i < NP; i++)
      begin
        if (cfg_addr == REG_PROC_LINK_STATE + 8'(i))
        begin
          st_nxt.pl_net[i] = cfg_wdata[LS_NET_LSB +: 2];
        end
      end
    end

    // a debug event beats a same-cycle write and names only its cause
    if (dbg_event)
    begin
      st_nxt.dbg_src = dbg_core ? 2'b10 : 2'b01;
    end

    // register reads, unmapped numbers answer zero
    if (rd_ok)
    begin
      case (cfg_addr)
        REG_SWITCH_CFG:
        begin
          st_nxt.rdata[CFG_LOCK_BIT] = st_r.lock;
          st_nxt.rdata[CFG_PLL_LOCK_BIT] = st_r.pll_lock;
          st_nxt.rdata[CFG_HDR_BIT] = st_r.hdr1;
        end
        REG_NODE_ID: st_nxt.rdata[15:0] = st_r.node_id;
        REG_SWITCH_CLOCK_RATIO: st_nxt.rdata[15:0] = st_r.sw_ratio;
        REG_REFERENCE_CLOCK_RATIO: st_nxt.rdata[15:0] = st_r.ref_ratio;
        REG_JTAG_IDENTITY: st_nxt.rdata = {JTAG_VERSION, JTAG_PART, JTAG_MAKER, 1'b1};
        REG_USER_CODE: st_nxt.rdata = {otp_user_code, METAL_ID};
        REG_ROUTE_DIR_LOW: st_nxt.rdata = st_r.dir_lo;
        REG_ROUTE_DIR_HIGH: st_nxt.rdata = st_r.dir_hi;
        REG_SPARE_A: st_nxt.rdata[1:0] = st_r.spare_a;
        REG_SPARE_B: st_nxt.rdata[1:0] = st_r.spare_b;
        REG_DEBUG_EVENT_ORIGIN:
        begin
          st_nxt.rdata[1:0] = st_r.dbg_src;
          st_nxt.rdata[DBG_RSV_BIT] = st_r.dbg_rsv;
        end
        default:
        begin
        end
      endcase
      for (int i = 0; i < NX; i++)
      begin
        if (cfg_addr == REG_EXT_LINK_STATE + 8'(i))
        begin
          st_nxt.rdata = xl_word[i];
        end
      end
      for (int i = 0; i < NP; i++)
      begin
        if (cfg_addr == REG_PROC_LINK_STATE + 8'(i))
        begin
          st_nxt.rdata = pl_word[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.sw_ratio <= SWITCH_CLOCK_RATIO_RESET;
      st_r.ref_ratio <= REFERENCE_CLOCK_RATIO_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs all straight from the state register
  assign cfg_ack = st_r.ack;
  assign cfg_rdata = st_r.rdata;
  assign rt_done = st_r.rt_done;
  assign rt_local = st_r.rt_local;
  assign rt_dir = st_r.rt_dir;
  assign switch_clock_ratio = st_r.sw_ratio;
  assign reference_clock_ratio = st_r.ref_ratio;
  assign node_id = st_r.node_id;
  assign pll_write_lock = st_r.pll_lock;
  assign one_byte_header = st_r.hdr1;
  assign spare_bits = {st_r.spare_b, st_r.spare_a};
  assign xl_dir = st_r.xl_dir;
  assign xl_net = st_r.xl_net;
  assign pl_net = st_r.pl_net;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_write_node(logic [15:0] v);
    cfg_valid && cfg_write && !st_r.lock && cfg_addr == REG_NODE_ID && cfg_wdata[15:0] == v;
  endsequence

  sequence s_route_same(logic [15:0] v);
    rt_valid && rt_dest == v;
  endsequence

  ratio_reset_a: assert property ($rose(rst_n) |-> reference_clock_ratio == 16'h0003
    && switch_clock_ratio == 16'h0000)
    else $error("clock ratios not at reset values");

  route_local_a: assert property (s_write_node(rt_dest) ##1 s_route_same(node_id)
    |=> rt_done && rt_local)
    else $error("matching id not delivered locally");

  dir_top_low_a: assert property (rt_valid && rt_dest[15:8] == node_id[15:8]
    && rt_dest[7] != node_id[7] |=> rt_dir == $past(st_r.dir_lo[31:28]) && !rt_local)
    else $error("dimension 7 direction wrong");

  dir_bit_zero_a: assert property (rt_valid && (rt_dest ^ node_id) == 16'h0001
    |=> rt_dir == $past(st_r.dir_lo[3:0]))
    else $error("dimension 0 direction wrong");

  dir_top_high_a: assert property (rt_valid && rt_dest[15] != node_id[15]
    |=> rt_dir == $past(st_r.dir_hi[31:28]))
    else $error("dimension 15 direction wrong");

  lock_hold_a: assert property (st_r.lock && cfg_valid && cfg_write
    |=> $stable(switch_clock_ratio) && $stable(node_id) && st_r.lock)
    else $error("write passed the lock");

  debug_origin_a: assert property (dbg_event && !dbg_core |=> st_r.dbg_src == 2'b01
    ##0 (st_r.dbg_src == 2'b01)[*1])
    else $error("debug origin not recorded");

  busy_read_a: assert property (rd_ok && cfg_addr == REG_EXT_LINK_STATE
    |=> cfg_ack && cfg_rdata[1:0] == $past({xl_dest_busy[0], xl_src_busy[0]}))
    else $error("link busy flags misread");

  spare_read_a: assert property (rd_ok && cfg_addr == REG_SPARE_A
    |=> cfg_rdata[31:2] == 30'h0 && cfg_rdata[1:0] == $past(st_r.spare_a))
    else $error("spare register read wrong");

  processor_link_nodir_a: assert property (rd_ok && cfg_addr == REG_PROC_LINK_STATE
    |=> cfg_rdata[15:6] == 10'h0 && cfg_rdata[31:26] == 6'h0)
    else $error("processor link reserved bits set");

endmodule

// *** dv/snrc_link_model.sv ***
`timescale 1ns/1ps
// status levels that the neighbouring links present to the register block
module snrc_link_model
  import snrc_pkg::*;
#(
  parameter int NX = NUM_EXT_LINK,
  parameter int NP = NUM_PROC_LINK
)
(
  // pattern select from the bench
  input wire logic [7:0] step,
  // external link status
  output logic [2*NX-1:0] xl_target,
  output logic [8*NX-1:0] xl_dest,
  output logic [NX-1:0] xl_junk,
  output logic [NX-1:0] xl_dest_busy,
  output logic [NX-1:0] xl_src_busy,
  // processor link status
  output logic [2*NP-1:0] pl_target,
  output logic [8*NP-1:0] pl_dest,
  output logic [NP-1:0] pl_junk,
  output logic [NP-1:0] pl_dest_busy,
  output logic [NP-1:0] pl_src_busy
);
  // ----------------------------------------------------------------
  // status pattern
  // ----------------------------------------------------------------
  // levels move only with step, so a read never sees them change mid-cycle
  always_comb
  begin
    for (int i = 0; i < NX; i++)
    begin
      xl_target[2*i +: 2] = 2'(i + int'(step));
      xl_dest[8*i +: 8] = 8'(8'h30 + i + int'(step));
      xl_junk[i] = i[0] ^ step[0];
      xl_dest_busy[i] = i[1];
      xl_src_busy[i] = ~i[0];
    end
    for (int i = 0; i < NP; i++)
    begin
      pl_target[2*i +: 2] = 2'(i + 1 + int'(step));
      pl_dest[8*i +: 8] = 8'(8'h50 + i + int'(step));
      pl_junk[i] = ~i[0];
      pl_dest_busy[i] = i[0];
      pl_src_busy[i] = i[1];
    end
  end
endmodule

// *** dv/snrc_top_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module snrc_top_tb
  import snrc_pkg::*;
;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} snrc_row_t;
  localparam int NX = NUM_EXT_LINK;
  localparam int NP = NUM_PROC_LINK;
  logic clock = 1'b0;
  logic rst_n, cfg_valid, cfg_write, cfg_ack, rt_valid, rt_done, rt_local, dbg_event, dbg_core;
  logic pll_write_lock, one_byte_header;
  logic [7:0] cfg_addr, step;
  logic [31:0] cfg_wdata, cfg_rdata, q, exp;
  logic [15:0] rt_dest, switch_clock_ratio, reference_clock_ratio, node_id;
  logic [16:0] mask;
  logic [13:0] otp_user_code;
  logic [3:0] rt_dir, spare_bits;
  logic [2*NX-1:0] xl_target, xl_net;
  logic [8*NX-1:0] xl_dest;
  logic [NX-1:0] xl_junk, xl_dest_busy, xl_src_busy;
  logic [2*NP-1:0] pl_target, pl_net;
  logic [8*NP-1:0] pl_dest;
  logic [NP-1:0] pl_junk, pl_dest_busy, pl_src_busy;
  logic [4*NX-1:0] xl_dir;
  int cycles = 0;
  int fail_count = 0;
  int tests_run = 0;
  // ordinary register cases: write, then read back
  snrc_row_t rows [22] = '{
    '{1'b1, REG_SWITCH_CLOCK_RATIO, 32'hffffffff, 32'h0}, '{1'b0, REG_SWITCH_CLOCK_RATIO, 32'h0, 32'h0000ffff},
    '{1'b1, REG_REFERENCE_CLOCK_RATIO, 32'h12345678, 32'h0}, '{1'b0, REG_REFERENCE_CLOCK_RATIO, 32'h0, 32'h5678},
    '{1'b1, REG_NODE_ID, 32'hffff00a5, 32'h0}, '{1'b0, REG_NODE_ID, 32'h0, 32'h000000a5},
    '{1'b1, REG_ROUTE_DIR_LOW, 32'h89abcdef, 32'h0}, '{1'b0, REG_ROUTE_DIR_LOW, 32'h0, 32'h89abcdef},
    '{1'b1, REG_ROUTE_DIR_HIGH, 32'h01234567, 32'h0}, '{1'b0, REG_ROUTE_DIR_HIGH, 32'h0, 32'h01234567},
    '{1'b1, REG_SPARE_A, 32'hffffffff, 32'h0}, '{1'b0, REG_SPARE_A, 32'h0, 32'h3},
    '{1'b1, REG_SPARE_B, 32'hfffffffe, 32'h0}, '{1'b0, REG_SPARE_B, 32'h0, 32'h2},
    '{1'b1, REG_JTAG_IDENTITY, 32'h0, 32'h0}, '{1'b0, REG_JTAG_IDENTITY, 32'h0, 32'h10001003},
    '{1'b1, REG_USER_CODE, 32'h0, 32'h0}, '{1'b0, REG_USER_CODE, 32'h0, {14'h2a5c, 18'h00001}},
    '{1'b1, 8'h06, 32'hffffffff, 32'h0}, '{1'b0, 8'h06, 32'h0, 32'h0},
    '{1'b1, REG_DEBUG_EVENT_ORIGIN, 32'hffffffff, 32'h0}, '{1'b0, REG_DEBUG_EVENT_ORIGIN, 32'h0, 32'h13}};

  always #10 clock = ~clock;

  snrc_top i_dut (.clock(clock), .rst_n(rst_n), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .rt_valid(rt_valid), .rt_dest(rt_dest), .rt_done(rt_done), .rt_local(rt_local), .rt_dir(rt_dir),
    .otp_user_code(otp_user_code), .dbg_event(dbg_event), .dbg_core(dbg_core),
    .xl_target(xl_target), .xl_dest(xl_dest), .xl_junk(xl_junk), .xl_dest_busy(xl_dest_busy),
    .xl_src_busy(xl_src_busy), .pl_target(pl_target), .pl_dest(pl_dest), .pl_junk(pl_junk),
    .pl_dest_busy(pl_dest_busy), .pl_src_busy(pl_src_busy), .switch_clock_ratio(switch_clock_ratio),
    .reference_clock_ratio(reference_clock_ratio), .node_id(node_id), .pll_write_lock(pll_write_lock),
    .one_byte_header(one_byte_header), .spare_bits(spare_bits), .xl_dir(xl_dir), .xl_net(xl_net),
    .pl_net(pl_net));

  snrc_link_model i_link (.step(step), .xl_target(xl_target), .xl_dest(xl_dest), .xl_junk(xl_junk),
    .xl_dest_busy(xl_dest_busy), .xl_src_busy(xl_src_busy), .pl_target(pl_target), .pl_dest(pl_dest),
    .pl_junk(pl_junk), .pl_dest_busy(pl_dest_busy), .pl_src_busy(pl_src_busy));

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // one access takes two cycles so the strobe is never lowered and raised in one step
  task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    cfg_valid = 1'b1;
    cfg_write = w;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clock);
    r = cfg_rdata;
    `CHK(cfg_ack, 1'b1)
    cfg_valid = 1'b0;
    @(negedge clock);
  endtask

  task automatic look(input logic [15:0] d);
    rt_valid = 1'b1;
    rt_dest = d;
    @(negedge clock);
    `CHK(rt_done, 1'b1)
    rt_valid = 1'b0;
    @(negedge clock);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0; cfg_valid = 1'b0; cfg_write = 1'b0; cfg_addr = 8'h0; cfg_wdata = 32'h0;
    rt_valid = 1'b0; rt_dest = 16'h0; otp_user_code = 14'h2a5c; dbg_event = 1'b0; dbg_core = 1'b0;
    step = 8'h0;
    repeat (6) @(negedge clock);
    `CHK(reference_clock_ratio, 16'h0003)
    rst_n = 1'b1;
    foreach (rows[k])
    begin
      cfg(rows[k].w, rows[k].a, rows[k].d, q);
      `CHK(q, rows[k].e)
    end
    `CHK({switch_clock_ratio, reference_clock_ratio, node_id, spare_bits}, {16'hffff, 16'h5678, 16'h00a5, 4'hb})
    $display("register table done");
    // tables hold 15-n for dimension n, so a pick that ignores them shows up
    look(16'h00a5);
    `CHK({rt_local, rt_dir}, 5'h10)
    for (int n = 0; n < 16; n++)
    begin
      mask = (17'h1 << (n + 1)) - 17'h1;
      look(16'h00a5 ^ mask[15:0]);
      `CHK({rt_local, rt_dir}, {1'b0, 4'(15 - n)})
    end
    $display("routing done");
    for (int i = 0; i < NX; i++)
    begin
      cfg(1'b1, 8'(REG_EXT_LINK_STATE + i), {20'hfffff, 4'(i + 1), 2'h3, 2'(i), 4'hf}, q);
      cfg(1'b0, 8'(REG_EXT_LINK_STATE + i), 32'h0, q);
      exp = {6'h0, xl_target[2*i +: 2], xl_dest[8*i +: 8], 4'h0, 4'(i + 1), 2'h0, 2'(i), 1'b0,
             xl_junk[i], xl_dest_busy[i], xl_src_busy[i]};
      `CHK(q, exp)
      `CHK({xl_dir[4*i +: 4], xl_net[2*i +: 2]}, {4'(i + 1), 2'(i)})
    end
    // move the far-side levels so processor links see a different pattern
    step = 8'h1;
    for (int i = 0; i < NP; i++)
    begin
      cfg(1'b1, 8'(REG_PROC_LINK_STATE + i), {26'h3ffffff, 2'(i + 1), 4'hf}, q);
      cfg(1'b0, 8'(REG_PROC_LINK_STATE + i), 32'h0, q);
      exp = {6'h0, pl_target[2*i +: 2], pl_dest[8*i +: 8], 10'h0, 2'(i + 1), 1'b0,
             pl_junk[i], pl_dest_busy[i], pl_src_busy[i]};
      `CHK(q, exp)
      `CHK(pl_net[2*i +: 2], 2'(i + 1))
    end
    cfg(1'b0, 8'h29, 32'h0, q);
    `CHK(q, 32'h0)
    cfg(1'b0, 8'h48, 32'h0, q);
    `CHK(q, 32'h0)
    $display("link status done");
    // latest event owner only: the other bit must drop
    dbg_event = 1'b1;
    @(negedge clock);
    dbg_event = 1'b0;
    cfg(1'b0, REG_DEBUG_EVENT_ORIGIN, 32'h0, q);
    `CHK(q[1:0], 2'b01)
    dbg_event = 1'b1;
    dbg_core = 1'b1;
    @(negedge clock);
    dbg_event = 1'b0;
    cfg(1'b0, REG_DEBUG_EVENT_ORIGIN, 32'h0, q);
    `CHK(q[1:0], 2'b10)
    $display("debug origin done");
    cfg(1'b1, REG_SWITCH_CFG, 32'h80000101, q);
    cfg(1'b1, REG_SWITCH_CLOCK_RATIO, 32'h00001234, q);
    cfg(1'b1, REG_SWITCH_CFG, 32'h0, q);
    cfg(1'b0, REG_SWITCH_CLOCK_RATIO, 32'h0, q);
    `CHK(q, 32'h0000ffff)
    cfg(1'b0, REG_SWITCH_CFG, 32'h0, q);
    `CHK({q, pll_write_lock, one_byte_header}, {32'h80000101, 2'b11})
    $display("lock done");
    // a second reset in mid-run must restore the ratios, node id, spare bits, link settings and route tables
    rst_n = 1'b0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    `CHK({switch_clock_ratio, reference_clock_ratio, node_id}, {16'h0, 16'h0003, 16'h0})
    `CHK({spare_bits, xl_dir, xl_net, pl_net}, '0)
    cfg(1'b0, REG_ROUTE_DIR_LOW, 32'h0, q);
    `CHK(q, 32'h0)
    cfg(1'b0, REG_ROUTE_DIR_HIGH, 32'h0, q);
    `CHK(q, 32'h0)
    $display("reset done");
    // node id write followed at once by a matching lookup: the new id must already count
    rt_dest = 16'h1234;
    cfg_valid = 1'b1;
    cfg_write = 1'b1;
    cfg_addr = REG_NODE_ID;
    cfg_wdata = 32'h0000_1234;
    @(negedge clock);
    cfg_valid = 1'b0;
    look(16'h1234);
    `CHK({rt_local, rt_dir}, 5'h10)
    // event and write in one cycle: the event owns the origin bits, the reserved bit still lands
    dbg_event = 1'b1;
    cfg_valid = 1'b1;
    cfg_write = 1'b1;
    cfg_addr = REG_DEBUG_EVENT_ORIGIN;
    cfg_wdata = 32'h0000_0011;
    @(negedge clock);
    dbg_event = 1'b0;
    cfg_valid = 1'b0;
    @(negedge clock);
    cfg(1'b0, REG_DEBUG_EVENT_ORIGIN, 32'h0, q);
    `CHK(q, 32'h0000_0012)
    $display("same-cycle cases done");
    wrap_up();
  end
endmodule
